// ===== common/harvest_pmc_defs.vh
// Constants for the harvest power mode controller: register map, fields, resets, timing.
// Assumes inclusion by bare name from the design files.
`ifndef HARVEST_PMC_DEFS_VH
`define HARVEST_PMC_DEFS_VH

`define PMC_ADDR_W 4
`define PMC_REG_CTRL 4'h0
`define PMC_REG_STATUS 4'h1
`define PMC_REG_WAKE 4'h2
`define PMC_REG_ID 4'h3

`define PMC_CTRL_AUX_OFF 0
`define PMC_CTRL_GND_OFF 1
`define PMC_CTRL_SLEEP 2
`define PMC_CTRL_AUX_MASK_LSB 4
`define PMC_CTRL_RESET 32'h0000_0070

`define PMC_ST_MODE_LSB 0
`define PMC_ST_JOINED 2
`define PMC_ST_BAT_LOW 3
`define PMC_ST_HARVESTER_LOW_FLAG 4
`define PMC_ST_APL_OVER 5
`define PMC_ST_MAIN_ON 6
`define PMC_ST_SEL_FOUR 7

`define PMC_WAKE_RESET 32'h0000_03E8
`define PMC_ID_VALUE 32'h0000_5A01

`define PMC_MODE_NORMAL 2'h0
`define PMC_MODE_PROTECT 2'h1
`define PMC_MODE_SLEEP 2'h2

`define PMC_TICK_NS 1000
`define PMC_CLK_NS 10
`define PMC_TICK_CYC (`PMC_TICK_NS / `PMC_CLK_NS)
// Last prescaler count of a tick, PMC_TICK_CYC - 1, held at the counter's width
`define PMC_TICK_LAST 16'h0063
`define PMC_AUX_N 3

`endif

// ===== hw/harvest_power_mode_controller.v
// Mode controller for a solar-harvesting power manager: mode machine, switches, indicators,
// Avalon-MM register slave. Assumes comparator results are synchronous to clock_i.
//
// Summary of operation
// (RQ1) In normal mode with the storage voltage in range the storage join switch is closed.
// (RQ2) A long-term storage voltage below the battery floor low level enters protection mode.
// (RQ3) Protection mode opens the join switch to shield the long-term element.
// (RQ4) The battery-low pin goes high for a low battery and always in protection mode.
// (RQ5) Protection mode keeps the main and auxiliary supplies on from solar or USB. Code keeps on only the auxiliary supplies set in CTRL mask bits 6:4.
// (RQ6) Normal mode lets configuration turn off the auxiliary supplies, ground switches or both.
// (RQ7) Sleep mode turns the main supply off and the serial interface is dead meanwhile.
// (RQ8) Sleep ends on the wake pin or the wake timer, re-enabling the main supply.
// (RQ9) The floor high level is the connected value while joined, else the disconnected value.
// (RQ10) The application ceiling uses separate high and low trips to set and clear over-limit.
// (RQ11) The harvester-low pin goes high when harvester energy is low.
// (RQ12) Chip select also picks four-wire (high) or two-wire serial mode.
// (RQ13) With the main supply off the host sees the serial pins as floating and dead.
// (RQ14) All digital pins are active high.
// (RQ15) Protection mode ends and storages rejoin once storage rises above the floor high level.
`include "harvest_pmc_defs.vh"
module harvest_power_mode_controller (
  input wire clock_i,
  input wire srst_i,
  input wire [`PMC_ADDR_W-1:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  input wire lts_below_floor_low_i,
  input wire lts_above_floor_high_con_i,
  input wire lts_above_floor_high_dis_i,
  input wire lts_in_range_i,
  input wire apl_above_ceiling_high_i,
  input wire apl_below_ceiling_low_i,
  input wire harvester_weak_i,
  input wire wake_i,
  input wire chip_select_i,
  output reg storage_join_o,
  output reg main_supply_o,
  output reg [`PMC_AUX_N-1:0] aux_supply_out_o,
  output reg [`PMC_AUX_N-1:0] aux_ground_switch_o,
  output reg battery_low_o,
  output reg harvester_low_flag_o,
  output reg apl_over_o,
  output reg serial_enable_o,
  output reg serial_four_wire_o
);
  localparam [1:0] ST_NORMAL = `PMC_MODE_NORMAL;
  localparam [1:0] ST_PROTECT = `PMC_MODE_PROTECT;
  localparam [1:0] ST_SLEEP = `PMC_MODE_SLEEP;

  reg [1:0] mode_q;
  reg [1:0] mode_d;
  reg [31:0] ctrl_q;
  reg [31:0] wake_q;
  reg sleep_req_q;
  reg rd_pending_q;
  reg [31:0] rd_data;
  wire apl_over;
  wire wake_expire;
  wire floor_high_ok;
  wire access;
  wire [31:0] bmask;

  hyst_compare u_apl (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .above_high_i(apl_above_ceiling_high_i),
    .below_low_i(apl_below_ceiling_low_i),
    .flag_o(apl_over)
  );

  wake_timer u_wake (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .run_i(mode_q == ST_SLEEP),
    .load_i(wake_q),
    .expire_o(wake_expire)
  );

  // Floor high level follows the present join state
  assign floor_high_ok = storage_join_o ? lts_above_floor_high_con_i
                                        : lts_above_floor_high_dis_i; // [RQ9]

  always @* begin
    mode_d = mode_q;
    case (mode_q)
      ST_NORMAL: begin
        if (lts_below_floor_low_i) begin
          mode_d = ST_PROTECT; // [RQ2]
        end else if (sleep_req_q) begin
          mode_d = ST_SLEEP;
        end
      end
      ST_PROTECT: begin
        if (floor_high_ok && !lts_below_floor_low_i) begin
          mode_d = ST_NORMAL; // [RQ15]
        end
      end
      ST_SLEEP: begin
        if (wake_i || wake_expire) begin
          mode_d = ST_NORMAL; // [RQ8]
        end
        if (lts_below_floor_low_i) begin
          mode_d = ST_PROTECT;
        end
      end
      default: begin
        mode_d = ST_NORMAL;
      end
    endcase
  end

  // Waitrequest drops one cycle after a request, so every access takes two cycles while the serial port is enabled
  assign access = (avs_read_i || avs_write_i) && avs_waitrequest_o && serial_enable_o;
  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1) begin : g_be
      assign bmask[8*b+7:8*b] = {8{avs_byteenable_i[b]}};
    end
  endgenerate

  always @* begin
    case (avs_address_i)
      `PMC_REG_CTRL: rd_data = ctrl_q;
      `PMC_REG_STATUS: rd_data = {24'h000000, serial_four_wire_o, main_supply_o, apl_over_o,
        harvester_low_flag_o, battery_low_o, storage_join_o, mode_q};
      `PMC_REG_WAKE: rd_data = wake_q;
      `PMC_REG_ID: rd_data = `PMC_ID_VALUE; // Arbitrary identification value
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always @(posedge clock_i) begin
    if (srst_i) begin
      mode_q <= ST_NORMAL;
      ctrl_q <= `PMC_CTRL_RESET;
      wake_q <= `PMC_WAKE_RESET;
      sleep_req_q <= 1'b0;
      rd_pending_q <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
      avs_waitrequest_o <= 1'b1;
      storage_join_o <= 1'b0;
      main_supply_o <= 1'b1;
      aux_supply_out_o <= {`PMC_AUX_N{1'b0}};
      aux_ground_switch_o <= {`PMC_AUX_N{1'b0}};
      battery_low_o <= 1'b0;
      harvester_low_flag_o <= 1'b0;
      apl_over_o <= 1'b0;
      serial_enable_o <= 1'b1;
      serial_four_wire_o <= 1'b0;
    end else begin
      mode_q <= mode_d;
      rd_pending_q <= 1'b0;
      avs_waitrequest_o <= ~access;
      if (access && avs_read_i) begin
        avs_readdata_o <= rd_data;
      end
      // Sleep request is a one-shot: consumed on entry, and dropped outside normal mode
      // so a request made in protection cannot fire long after the fact
      if (mode_d != ST_NORMAL) begin
        sleep_req_q <= 1'b0;
      end
      if (access && avs_write_i) begin
        if (avs_address_i == `PMC_REG_CTRL) begin
          ctrl_q <= (ctrl_q & ~bmask) | (avs_writedata_i & bmask);
          if (avs_byteenable_i[0] && avs_writedata_i[`PMC_CTRL_SLEEP]) begin
            sleep_req_q <= 1'b1;
          end
        end else if (avs_address_i == `PMC_REG_WAKE) begin
          wake_q <= (wake_q & ~bmask) | (avs_writedata_i & bmask);
        end
      end
      storage_join_o <= (mode_d == ST_NORMAL) && lts_in_range_i; // [RQ1] [RQ3]
      main_supply_o <= (mode_d != ST_SLEEP); // [RQ5] [RQ7] [RQ8]
      // Serial port dead while the main supply is off
      serial_enable_o <= (mode_d != ST_SLEEP); // [RQ7] [RQ13]
      serial_four_wire_o <= chip_select_i; // [RQ12]
      if (mode_d == ST_NORMAL) begin
        aux_supply_out_o <= ctrl_q[`PMC_CTRL_AUX_OFF] ? {`PMC_AUX_N{1'b0}}
          : ctrl_q[`PMC_CTRL_AUX_MASK_LSB +: `PMC_AUX_N]; // [RQ6]
        aux_ground_switch_o <= ctrl_q[`PMC_CTRL_GND_OFF] ? {`PMC_AUX_N{1'b0}}
          : ctrl_q[`PMC_CTRL_AUX_MASK_LSB +: `PMC_AUX_N]; // [RQ6]
      end else if (mode_d == ST_PROTECT) begin
        aux_supply_out_o <= ctrl_q[`PMC_CTRL_AUX_MASK_LSB +: `PMC_AUX_N]; // [RQ5]
        aux_ground_switch_o <= ctrl_q[`PMC_CTRL_AUX_MASK_LSB +: `PMC_AUX_N];
      end else begin
        aux_supply_out_o <= {`PMC_AUX_N{1'b0}};
        aux_ground_switch_o <= {`PMC_AUX_N{1'b0}};
      end
      battery_low_o <= (mode_d == ST_PROTECT) || lts_below_floor_low_i; // [RQ4] [RQ14]
      harvester_low_flag_o <= harvester_weak_i; // [RQ11]
      apl_over_o <= apl_over; // [RQ10]
    end
  end
endmodule

// ===== hw/hyst_compare.v
// Hysteresis flag: set on the high trip, cleared on the low trip.
// Assumes trip inputs come from comparators synchronous to clock_i.
`include "harvest_pmc_defs.vh"
module hyst_compare (
  input wire clock_i,
  input wire srst_i,
  input wire above_high_i,
  input wire below_low_i,
  output reg flag_o
);
  always @(posedge clock_i) begin
    if (srst_i) begin
      flag_o <= 1'b0;
    end else if (above_high_i) begin
      flag_o <= 1'b1; // [RQ10]
    end else if (below_low_i) begin
      flag_o <= 1'b0; // [RQ10]
    end
  end
endmodule

// ===== hw/wake_timer.v
// Sleep wake timer counting microsecond ticks down from a loaded value.
// Assumes run_i stays high for the whole sleep period.
`include "harvest_pmc_defs.vh"
module wake_timer (
  input wire clock_i,
  input wire srst_i,
  input wire run_i,
  input wire [31:0] load_i,
  output reg expire_o
);
  reg [31:0] count_q;
  reg [15:0] tick_q;
  wire tick;
  assign tick = (tick_q == `PMC_TICK_LAST);
  always @(posedge clock_i) begin
    if (srst_i || !run_i) begin
      count_q <= load_i;
      tick_q <= 16'h0000;
      expire_o <= 1'b0;
    end else begin
      tick_q <= tick ? 16'h0000 : tick_q + 16'h0001;
      if (tick && count_q != 32'h0000_0000) begin
        count_q <= count_q - 32'h0000_0001;
      end
      expire_o <= (count_q == 32'h0000_0000); // [RQ8]
    end
  end
endmodule

// ===== sim/lts_sense_model.sv
// Storage sense model: turns a storage level in mV into comparator flags.
// Assumes an ideal comparator bank with no noise or delay.
module lts_sense_model #(
  parameter logic [15:0] FLOOR_LO = 16'h07D0,
  parameter logic [15:0] HIGH_CON = 16'h0960,
  parameter logic [15:0] HIGH_DIS = 16'h0A28,
  parameter logic [15:0] TOP = 16'h0E10
) (
  input logic [15:0] lts_mv_i,
  output logic below_lo_o,
  output logic above_con_o,
  output logic above_dis_o,
  output logic in_range_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign below_lo_o = lts_mv_i < FLOOR_LO;
  assign above_con_o = lts_mv_i > HIGH_CON;
  // Disconnected trip sits higher, so a rejoin needs extra margin
  assign above_dis_o = lts_mv_i > HIGH_DIS;
  assign in_range_o = !below_lo_o && lts_mv_i <= TOP;
endmodule

// ===== sim/pmc_chk.sv
// Port checker for the power mode controller.
// Assumes it is bound into every controller instance.
module pmc_chk (
  input logic clock_i,
  input logic srst_i,
  input logic avs_waitrequest_o,
  input logic lts_below_floor_low_i,
  input logic apl_above_ceiling_high_i,
  input logic apl_below_ceiling_low_i,
  input logic harvester_weak_i,
  input logic wake_i,
  input logic chip_select_i,
  input logic storage_join_o,
  input logic main_supply_o,
  input logic battery_low_o,
  input logic harvester_low_flag_o,
  input logic apl_over_o,
  input logic serial_enable_o,
  input logic serial_four_wire_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  a_protect_entry: assert property (
    lts_below_floor_low_i |=> !storage_join_o && battery_low_o) else $error("protect entry");
  a_protect_main: assert property (
    lts_below_floor_low_i |=> main_supply_o) else $error("supply lost in protect");
  a_sleep_serial: assert property (
    !main_supply_o |-> !serial_enable_o) else $error("serial alive in sleep");
  a_sleep_stall: assert property (
    !serial_enable_o |-> avs_waitrequest_o) else $error("bus answered in sleep");
  a_wake_pin: assert property (
    !main_supply_o && wake_i |=> main_supply_o) else $error("no wake on pin");
  a_harvest_flag: assert property (
    harvester_weak_i |=> harvester_low_flag_o) else $error("harvester flag");
  a_cs_mode: assert property (
    $rose(chip_select_i) |=> serial_four_wire_o) else $error("four wire select");
  a_apl_set: assert property (
    apl_above_ceiling_high_i && !apl_below_ceiling_low_i |-> ##2 apl_over_o)
    else $error("ceiling set");
  a_apl_clear: assert property (
    apl_below_ceiling_low_i && !apl_above_ceiling_high_i |-> ##2 !apl_over_o)
    else $error("ceiling clear");
  cover property (!main_supply_o ##1 main_supply_o);
  cover property ($rose(battery_low_o));
  cover property ($rose(apl_over_o));
endmodule
bind harvest_power_mode_controller pmc_chk i_pmc_chk (.*);

// ===== sim/test_harvest_power_mode_controller.sv
// Bench for the power mode controller: Avalon tasks plus directed mode tests.
// Assumes the controller, its checker and the storage sense model are compiled.
`include "harvest_pmc_defs.vh"
module test_harvest_power_mode_controller;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd_q = 1'b0;
  logic wr_q = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rd;
  logic [15:0] lts_mv = 16'h0BB8;
  logic hi = 1'b0;
  logic lo_t = 1'b0;
  logic hrv = 1'b0;
  logic wake = 1'b0;
  logic cs = 1'b0;
  wire lo, con, dis, rng, wait_n, join_s, main, bl, hl, ov, se, fw;
  wire [31:0] rdata;
  wire [2:0] aux, gnd;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  int n;
  always #5 clock_i = ~clock_i;
  lts_sense_model i_lts_sense_model (.lts_mv_i(lts_mv), .below_lo_o(lo), .above_con_o(con),
    .above_dis_o(dis), .in_range_o(rng));
  harvest_power_mode_controller i_harvest_power_mode_controller (.clock_i(clock_i),
    .srst_i(srst_i), .avs_address_i(adr), .avs_read_i(rd_q), .avs_write_i(wr_q),
    .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_n), .lts_below_floor_low_i(lo), .lts_above_floor_high_con_i(con),
    .lts_above_floor_high_dis_i(dis), .lts_in_range_i(rng), .apl_above_ceiling_high_i(hi),
    .apl_below_ceiling_low_i(lo_t), .harvester_weak_i(hrv), .wake_i(wake),
    .chip_select_i(cs), .storage_join_o(join_s), .main_supply_o(main),
    .aux_supply_out_o(aux), .aux_ground_switch_o(gnd), .battery_low_o(bl),
    .harvester_low_flag_o(hl), .apl_over_o(ov), .serial_enable_o(se),
    .serial_four_wire_o(fw));
  task wrap_up;
    if (failures == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  // Request is held until waitrequest is seen low; only then released
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    adr <= a;
    wd <= d;
    wr_q <= w;
    rd_q <= !w;
    do @(posedge clock_i); while (wait_n !== 1'b0);
    rd = rdata;
    wr_q <= 1'b0;
    rd_q <= 1'b0;
  endtask
  task step(input int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc > 5000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    repeat (10) @(posedge clock_i);
    srst_i <= 1'b0;
    bus(1'b0, `PMC_REG_CTRL, 32'h0);
    chk("ctrl", `PMC_CTRL_RESET, rd);
    bus(1'b1, `PMC_REG_ID, 32'h0);
    bus(1'b0, `PMC_REG_ID, 32'h0);
    chk("id", `PMC_ID_VALUE, rd);
    bus(1'b0, 4'hF, 32'h0);
    chk("unmapped", 32'h0, rd);
    step(2);
    chk("join", 32'h1, join_s);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `PMC_REG_CTRL, 32'h70 | i);
      step(2);
      chk("aux", i[0] ? 3'h0 : 3'h7, aux);
      chk("gnd", i[1] ? 3'h0 : 3'h7, gnd);
    end
    lts_mv <= 16'h05DC;
    step(2);
    chk("join", 32'h0, join_s);
    chk("batlow", 32'h1, bl);
    chk("main", 32'h1, main);
    chk("aux", 32'h7, aux);
    bus(1'b0, `PMC_REG_STATUS, 32'h0);
    chk("mode", `PMC_MODE_PROTECT, rd[1:0]);
    lts_mv <= 16'h09C4;
    step(3);
    chk("join", 32'h0, join_s);
    lts_mv <= 16'h0A8C;
    step(3);
    chk("join", 32'h1, join_s);
    chk("batlow", 32'h0, bl);
    hrv <= 1'b1;
    step(2);
    chk("hrvlow", 32'h1, hl);
    hrv <= 1'b0;
    hi <= 1'b1;
    step(3);
    chk("hrvlow", 32'h0, hl);
    chk("over", 32'h1, ov);
    hi <= 1'b0;
    step(3);
    chk("over", 32'h1, ov);
    lo_t <= 1'b1;
    cs <= 1'b1;
    step(3);
    chk("over", 32'h0, ov);
    chk("four", 32'h1, fw);
    lo_t <= 1'b0;
    bus(1'b1, `PMC_REG_CTRL, 32'h74);
    step(2);
    chk("main", 32'h0, main);
    chk("serial", 32'h0, se);
    wake <= 1'b1;
    step(2);
    chk("main", 32'h1, main);
    wake <= 1'b0;
    bus(1'b1, `PMC_REG_WAKE, 32'h2);
    bus(1'b1, `PMC_REG_CTRL, 32'h74);
    step(2);
    chk("main", 32'h0, main);
    n = 0;
    // Two ticks of 100 cycles each must pass before the timer wakes
    while (main !== 1'b1 && n < 600) begin
      @(posedge clock_i);
      n++;
    end
    chk("timer", 32'h1, n >= 190 && n < 600);
    wrap_up();
  end
endmodule
